/* File: oce_top.sv */
// Behaviour
// - Low-set phase stage starts above level, start signal after preset delay
// - Low-set phase operates on definite time or computed inverse time
// - High-set phase start signal after fixed 40 ms, then operate time
// - Very-high-set phase starts above level, delay, then operate time
// - High-set and very-high-set stages selectable instantaneous or definite time
// - Low-set ground stage: start delay, then definite or inverse operate
// - High-set ground start signal after 50 ms, then operate time
// - Discontinuity stage start signal after 150 ms, then definite operate
// - Discontinuity stage can be disabled completely
// - Low-set stages choose definite or inverse; six inverse curves
// - Four standard inverse curves plus two special inverse curves
// - Two trip and four signal outputs fed by start/operate matrix; backup trip fed by breaker-failure timer when enabled
// - Control input blocks stages, unlatches trips, or switches setting bank
// - A configuration field picks the control input function
// - Permanent internal fault drops alarm and suppresses trip and signal outputs
// - Currents evaluated on every measurement update without pause
// - Settings written locally or remotely; remote party sends valid values
// - Backup trip after 0.1 to 1 s if fault persists past main trip
// - Configuration selects latching or following heavy-duty trip outputs
// - Alarm output held active normally, released on internal fault
`timescale 1ns/1ps
`default_nettype none

module oce_top #(
  parameter int MS_CYCLES = oce_pkg::MS_CYCLES_DEF
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       meas_valid,
  input  wire logic [oce_pkg::WCUR-1:0]   i_l1,
  input  wire logic [oce_pkg::WCUR-1:0]   i_l2,
  input  wire logic [oce_pkg::WCUR-1:0]   i_l3,
  input  wire logic [oce_pkg::WCUR-1:0]   i_n,
  input  wire logic [oce_pkg::WCUR-1:0]   unbalance,
  input  wire logic [oce_pkg::WCUR-1:0]   level_main [oce_pkg::NSTAGE],
  input  wire logic [oce_pkg::WCUR-1:0]   level_second [oce_pkg::NSTAGE],
  input  wire logic [oce_pkg::WTIME-1:0]  op_ms_main [oce_pkg::NSTAGE],
  input  wire logic [oce_pkg::WTIME-1:0]  op_ms_second [oce_pkg::NSTAGE],
  input  wire oce_pkg::oce_curve_t        phase_curve,
  input  wire oce_pkg::oce_curve_t        ground_curve,
  input  wire logic [oce_pkg::WTIME-1:0]  inv_ms_phase,
  input  wire logic [oce_pkg::WTIME-1:0]  inv_ms_ground,
  input  wire logic [2:0]                 instant_sel,
  input  wire logic                       disc_enable,
  input  wire logic                       control_input_pin,
  input  wire oce_pkg::oce_ctl_fn_t       control_input_function_select,
  input  wire logic [oce_pkg::NSTAGE-1:0] block_mask,
  input  wire logic                       trip_latch_select,
  input  wire logic [2*oce_pkg::NSTAGE-1:0] out_route [oce_pkg::NOUT],
  input  wire logic                       cbf_enable,
  input  wire logic [oce_pkg::WTIME-1:0]  cbf_ms,
  input  wire logic                       self_fault_pin,
  output logic                            main_trip_output,
  output logic                            backup_trip_output,
  output logic [oce_pkg::NSIG-1:0]        signal_output,
  output logic                            self_check_alarm_output,
  output logic [oce_pkg::NSTAGE-1:0]      stage_start,
  output logic [oce_pkg::NSTAGE-1:0]      stage_operate,
  output logic                            bank_second
);

  localparam int NS = oce_pkg::NSTAGE;
  localparam int WC = oce_pkg::WCUR;
  localparam int WT = oce_pkg::WTIME;
  localparam int TW = $clog2(MS_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(MS_CYCLES - 1);

  localparam logic [WT-1:0] START_MS [NS] = '{
    oce_pkg::LS_PHASE_START_MS,
    oce_pkg::HS_PHASE_START_MS,
    oce_pkg::VHS_PHASE_START_MS,
    oce_pkg::LS_GROUND_START_MS,
    oce_pkg::HS_GROUND_START_MS,
    oce_pkg::DISC_START_MS
  };

  // Pin inputs through two flip-flops
  logic [1:0] pins_s;
  wire        ctl_s   = pins_s[0];
  wire        fault_s = pins_s[1];

  oce_sync #(
    .W (2)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .din   ({self_fault_pin, control_input_pin}),
    .dout  (pins_s)
  );

  // Millisecond tick
  logic [TW-1:0] tick_cnt_reg;
  wire           tick_ms = (tick_cnt_reg == TICK_LAST);

  always_ff @(posedge clk) begin
    if (reset) begin
      tick_cnt_reg <= '0;
    end else if (tick_ms) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + {{(TW-1){1'b0}}, 1'b1};
    end
  end

  // Control input function
  wire fn_block   = control_input_function_select == oce_pkg::oce_ctl_block;
  wire fn_unlatch = control_input_function_select == oce_pkg::oce_ctl_unlatch;
  wire fn_bank    = control_input_function_select == oce_pkg::oce_ctl_bank;

  wire [NS-1:0] stage_block = (fn_block & ctl_s) ? block_mask : '0;
  wire          unlatch     = fn_unlatch & ctl_s;
  assign bank_second        = fn_bank & ctl_s;

  // Measured value per stage
  wire [WC-1:0] max12     = (i_l1 > i_l2) ? i_l1 : i_l2;
  wire [WC-1:0] phase_max = (max12 > i_l3) ? max12 : i_l3;

  logic [WC-1:0] meas [NS];
  assign meas[oce_pkg::ST_LS_PHASE]  = phase_max;
  assign meas[oce_pkg::ST_HS_PHASE]  = phase_max;
  assign meas[oce_pkg::ST_VHS_PHASE] = phase_max;
  assign meas[oce_pkg::ST_LS_GROUND] = i_n;
  assign meas[oce_pkg::ST_HS_GROUND] = i_n;
  assign meas[oce_pkg::ST_DISC]      = unbalance;

  // Active setting bank; settings arrive already validated
  logic [WC-1:0] level [NS];
  logic [WT-1:0] op_def [NS];
  logic [NS-1:0] over_cmp;
  logic [NS-1:0] over_reg;

  // Curve codes beyond the six defined fall back to definite time
  wire phase_inv  = (phase_curve != oce_pkg::oce_curve_definite) &
                    (phase_curve <= oce_pkg::oce_curve_log_inverse_curve_b);
  wire ground_inv = (ground_curve != oce_pkg::oce_curve_definite) &
                    (ground_curve <= oce_pkg::oce_curve_log_inverse_curve_b);

  logic [WT-1:0] op_time [NS];
  logic [NS-1:0] instant_vec;
  logic [NS-1:0] enable_vec;

  assign instant_vec = {1'b0, instant_sel[2], 1'b0, instant_sel[1], instant_sel[0], 1'b0};
  assign enable_vec  = {disc_enable, {(NS-1){1'b1}}};

  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_stage
      assign level[g]    = bank_second ? level_second[g] : level_main[g];
      assign op_def[g]   = bank_second ? op_ms_second[g] : op_ms_main[g];
      assign over_cmp[g] = meas[g] > level[g];

      if (g == oce_pkg::ST_LS_PHASE) begin : g_ls_ph
        assign op_time[g] = phase_inv ? inv_ms_phase : op_def[g];
      end else if (g == oce_pkg::ST_LS_GROUND) begin : g_ls_gr
        assign op_time[g] = ground_inv ? inv_ms_ground : op_def[g];
      end else begin : g_def
        assign op_time[g] = op_def[g];
      end

      // Start delays per stage: 40 ms, 50 ms, 150 ms for the fixed ones
      oce_stage #(
        .W (WT)
      ) u_stage (
        .clk      (clk),
        .reset    (reset),
        .tick_ms  (tick_ms),
        .enable   (enable_vec[g]),
        .over     (over_reg[g]),
        .block    (stage_block[g]),
        .instant  (instant_vec[g]),
        .start_ms (START_MS[g]),
        .op_ms    (op_time[g]),
        .start    (stage_start[g]),
        .operate  (stage_operate[g])
      );
    end
  endgenerate

  // Comparisons refreshed on every measurement update
  always_ff @(posedge clk) begin
    if (reset) begin
      over_reg <= '0;
    end else if (meas_valid) begin
      over_reg <= over_cmp;
    end
  end

  // Output matrix: 12 sources to 6 outputs
  wire [2*NS-1:0]              sources = {stage_operate, stage_start};
  logic [oce_pkg::NOUT-1:0]    col_hit;

  generate
    for (g = 0; g < oce_pkg::NOUT; g++) begin : g_matrix
      assign col_hit[g] = |(sources & out_route[g]);
    end
  endgenerate

  // Breaker-failure timer reuses the stage sequencer
  wire [WT-1:0] cbf_lim = (cbf_ms < oce_pkg::CBF_MIN_MS) ? oce_pkg::CBF_MIN_MS :
                          (cbf_ms > oce_pkg::CBF_MAX_MS) ? oce_pkg::CBF_MAX_MS :
                          cbf_ms;
  wire          fault_any = |stage_start;
  logic         trip_main_q;
  logic         cbf_trip;

  oce_stage #(
    .W (WT)
  ) u_cbf (
    .clk      (clk),
    .reset    (reset),
    .tick_ms  (tick_ms),
    .enable   (cbf_enable),
    .over     (trip_main_q & fault_any),
    .block    (1'b0),
    .instant  (1'b1),
    .start_ms (cbf_lim),
    .op_ms    (oce_pkg::TIME_RST),
    .start    (cbf_trip),
    .operate  ()
  );

  // Heavy-duty trips: latch or follow; a new trip wins over unlatch
  logic [1:0] trip_hold_reg;
  wire  [1:0] trip_raw  = {cbf_enable ? cbf_trip : col_hit[oce_pkg::OUT_BACKUP],
                           col_hit[oce_pkg::OUT_MAIN]};
  wire  [1:0] trip_next = trip_latch_select ?
                          (trip_raw | (trip_hold_reg & ~{2{unlatch}})) :
                          trip_raw;
  assign trip_main_q = trip_hold_reg[0];

  // Permanent internal fault is held until reset
  logic fault_latched_reg;
  logic [oce_pkg::NSIG-1:0] sig_reg;
  logic main_reg;
  logic backup_reg;
  logic alarm_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      fault_latched_reg <= 1'b0;
      trip_hold_reg     <= 2'h0;
    end else begin
      fault_latched_reg <= fault_latched_reg | fault_s;
      trip_hold_reg     <= trip_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      main_reg   <= 1'b0;
      backup_reg <= 1'b0;
      sig_reg    <= '0;
      alarm_reg  <= 1'b0;
    end else begin
      main_reg   <= trip_hold_reg[0] & ~fault_latched_reg;
      backup_reg <= trip_hold_reg[1] & ~fault_latched_reg;
      sig_reg    <= col_hit[oce_pkg::NOUT-1:oce_pkg::OUT_SIG0] &
                    {oce_pkg::NSIG{~fault_latched_reg}};
      alarm_reg  <= ~fault_latched_reg;
    end
  end

  assign main_trip_output        = main_reg;
  assign backup_trip_output      = backup_reg;
  assign signal_output           = sig_reg;
  assign self_check_alarm_output = alarm_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_fault_suppress: assert property (fault_latched_reg |=>
      !main_trip_output && !backup_trip_output && signal_output == '0)
    else $error("outputs active during internal fault");
  a_alarm_level: assert property (!$past(reset) |->
      self_check_alarm_output == !$past(fault_latched_reg))
    else $error("alarm output not held in normal operation");
  a_disc_disabled: assert property (!disc_enable |=> !stage_start[oce_pkg::ST_DISC])
    else $error("disabled discontinuity stage started");
  a_ctl_block: assert property (fn_block && ctl_s
      |=> (stage_operate & $past(block_mask)) == '0)
    else $error("blocked stage operated");
  a_bank_fn: assert property (fn_bank && !$past(reset) && !$past(reset, 2)
      |-> bank_second == $past(control_input_pin, 2))
    else $error("bank selection does not follow control input");
  a_latch_hold: assert property (trip_latch_select && trip_hold_reg[0] && !unlatch
      |=> trip_hold_reg[0])
    else $error("latched trip released without unlatch");
  a_meas_hold: assert property (!meas_valid |=> $stable(over_reg))
    else $error("comparison changed without update");
  a_backup_cause: assert property (cbf_enable && $rose(cbf_trip)
      |-> $past(trip_main_q) && $past(fault_any))
    else $error("backup trip without main trip and fault");

  c_main_trip: cover property ($rose(main_trip_output));
  c_backup_trip: cover property (cbf_enable && $rose(backup_trip_output));
  c_bank_switch: cover property ($rose(bank_second));

endmodule // oce_top

`default_nettype wire

/* File: oce_pkg.sv */
package oce_pkg;

  localparam int NSTAGE = 6;
  localparam int NOUT   = 6;
  localparam int NSIG   = 4;
  localparam int WTIME  = 16;
  localparam int WCUR   = 16;

  // Stage indices
  localparam int ST_LS_PHASE  = 0;
  localparam int ST_HS_PHASE  = 1;
  localparam int ST_VHS_PHASE = 2;
  localparam int ST_LS_GROUND = 3;
  localparam int ST_HS_GROUND = 4;
  localparam int ST_DISC      = 5;

  // Output matrix columns
  localparam int OUT_MAIN   = 0;
  localparam int OUT_BACKUP = 1;
  localparam int OUT_SIG0   = 2;

  // Timing base: one tick per millisecond
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS       = 1000000;
  localparam int MS_CYCLES_DEF = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Start delays in ms, by stage index
  localparam logic [WTIME-1:0] LS_PHASE_START_MS  = 16'h0014;
  localparam logic [WTIME-1:0] HS_PHASE_START_MS  = 16'h0028;
  localparam logic [WTIME-1:0] VHS_PHASE_START_MS = 16'h0014;
  localparam logic [WTIME-1:0] LS_GROUND_START_MS = 16'h0014;
  localparam logic [WTIME-1:0] HS_GROUND_START_MS = 16'h0032;
  localparam logic [WTIME-1:0] DISC_START_MS      = 16'h0096;

  // Breaker-failure time window in ms
  localparam logic [WTIME-1:0] CBF_MIN_MS = 16'h0064;
  localparam logic [WTIME-1:0] CBF_MAX_MS = 16'h03e8;

  localparam logic [WTIME-1:0] TIME_RST = 16'h0000;
  localparam logic [WCUR-1:0]  CUR_RST  = 16'h0000;

  typedef enum logic [1:0] {
    oce_ctl_block   = 2'h0,
    oce_ctl_unlatch = 2'h1,
    oce_ctl_bank    = 2'h2
  } oce_ctl_fn_t;

  typedef enum logic [2:0] {
    oce_curve_definite                = 3'h0,
    oce_curve_normal                  = 3'h1,
    oce_curve_very                    = 3'h2,
    oce_curve_extreme                 = 3'h3,
    oce_curve_long                    = 3'h4,
    oce_curve_special_inverse_curve_a = 3'h5,
    oce_curve_log_inverse_curve_b     = 3'h6
  } oce_curve_t;

endpackage

/* File: oce_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module oce_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule // oce_sync

`default_nettype wire

/* File: oce_stage.sv */
`timescale 1ns/1ps
`default_nettype none

module oce_stage #(
  parameter int W = oce_pkg::WTIME
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         tick_ms,
  input  wire logic         enable,
  input  wire logic         over,
  input  wire logic         block,
  input  wire logic         instant,
  input  wire logic [W-1:0] start_ms,
  input  wire logic [W-1:0] op_ms,
  output logic              start,
  output logic              operate
);

  typedef enum logic [3:0] {
    oce_st_idle  = 4'h1,
    oce_st_delay = 4'h2,
    oce_st_run   = 4'h4,
    oce_st_op    = 4'h8
  } oce_stage_state_t;

  oce_stage_state_t state_reg, state_next;
  logic [W-1:0]     cnt_reg, cnt_next;

  wire         active   = enable & over;
  wire [W-1:0] cnt_inc  = cnt_reg + {{(W-1){1'b0}}, 1'b1};
  wire         start_ok = cnt_reg >= start_ms;
  wire         op_ok    = instant | (cnt_reg >= op_ms);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (!active) begin
      state_next = oce_st_idle;
      cnt_next   = '0;
    end else begin
      unique case (state_reg)
        oce_st_idle: begin
          state_next = oce_st_delay;
          cnt_next   = '0;
        end
        oce_st_delay: begin
          if (start_ok) begin
            state_next = oce_st_run;
            cnt_next   = '0;
          end else if (tick_ms) begin
            cnt_next = cnt_inc;
          end
        end
        oce_st_run: begin
          if (block) begin
            cnt_next = cnt_reg;
          end else if (op_ok) begin
            state_next = oce_st_op;
          end else if (tick_ms) begin
            cnt_next = cnt_inc;
          end
        end
        oce_st_op: begin
          if (block) begin
            state_next = oce_st_run;
          end
        end
        default: begin
          state_next = oce_st_idle;
          cnt_next   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= oce_st_idle;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign start   = (state_reg == oce_st_run) | (state_reg == oce_st_op);
  assign operate = (state_reg == oce_st_op) & ~block;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_drop_clears: assert property (!active |=> !start && !operate)
    else $error("stage output stayed after level dropped");
  a_block_no_op: assert property (block |=> !operate)
    else $error("blocked stage operated");
  a_start_delay: assert property ($rose(start) |-> $past(cnt_reg) >= $past(start_ms))
    else $error("start asserted before start delay");

  c_stage_op: cover property ($rose(operate));

endmodule // oce_stage

`default_nettype wire

/* File: oce_line_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Feeders behind the current transformers plus one breaker.
// The breaker opens a fixed time after a trip unless told to stick.
module oce_line_model #(
  parameter int OPEN_CYC = 20
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [2:0]  fault_sel,
  input  wire logic [15:0] fault_amp,
  input  wire logic        stuck,
  input  wire logic        trip,
  output logic             meas_valid,
  output logic [15:0]      i_l1,
  output logic [15:0]      i_l2,
  output logic [15:0]      i_l3,
  output logic [15:0]      i_n,
  output logic [15:0]      unbalance
);
  logic [7:0]  cnt_reg;
  logic        open_reg;
  int          open_cnt;
  logic [15:0] load;

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg  <= 8'h00;
      open_reg <= 1'b0;
      open_cnt <= 0;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      // Fault removed: breaker recloses
      if (fault_sel == 3'h0) begin
        open_reg <= 1'b0;
        open_cnt <= 0;
      end else if (trip && !stuck && !open_reg) begin
        open_cnt <= open_cnt + 1;
        if (open_cnt == OPEN_CYC) open_reg <= 1'b1;
      end
    end
  end

  // Load current stays well under any start level used
  assign load       = open_reg ? 16'h0000 : {8'h00, cnt_reg};
  assign meas_valid = (cnt_reg[1:0] == 2'h0);
  assign i_l1       = (fault_sel == 3'h1 && !open_reg) ? fault_amp : load;
  assign i_l2       = (fault_sel == 3'h2 && !open_reg) ? fault_amp : load;
  assign i_l3       = (fault_sel == 3'h3 && !open_reg) ? fault_amp : load;
  assign i_n        = (fault_sel == 3'h4 && !open_reg) ? fault_amp : 16'h0000;
  assign unbalance  = (fault_sel == 3'h5 && !open_reg) ? fault_amp : 16'h0000;
endmodule // oce_line_model

`default_nettype wire

/* File: oce_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module oce_top_tb_top;
  localparam int MS = 10;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        mv, den = 1'b1, pin = 1'b0, latch = 1'b0, cbf_en = 1'b0;
  logic        selff = 1'b0, stuck = 1'b0, mto, bto, alarm, bank;
  logic [15:0] l1, l2, l3, in_n, unb, inv = 16'h0002, cbf_t = 16'h0064;
  logic [15:0] amp = 16'h0800;
  logic [15:0] lvm [6], lvs [6], opm [6], ops [6];
  logic [11:0] rte [6];
  logic [2:0]  inst = 3'h0, fsel = 3'h0;
  logic [5:0]  bmask = 6'h00, sst, sop;
  logic [3:0]  sig;
  oce_pkg::oce_curve_t  crv = oce_pkg::oce_curve_definite;
  oce_pkg::oce_ctl_fn_t fn = oce_pkg::oce_ctl_unlatch;
  wire  [14:0] obs = {sig[0], bto, mto, sop, sst};
  int          errors = 0, checks = 0;
  integer      seed = 32'h8982e1da;

  always #25 clk = ~clk;

  oce_line_model line (.clk(clk), .reset(reset), .fault_sel(fsel), .fault_amp(amp),
    .stuck(stuck), .trip(mto), .meas_valid(mv), .i_l1(l1), .i_l2(l2), .i_l3(l3),
    .i_n(in_n), .unbalance(unb));

  oce_top #(.MS_CYCLES(MS)) dut (.clk(clk), .reset(reset), .meas_valid(mv),
    .i_l1(l1), .i_l2(l2), .i_l3(l3), .i_n(in_n), .unbalance(unb),
    .level_main(lvm), .level_second(lvs), .op_ms_main(opm), .op_ms_second(ops),
    .phase_curve(crv), .ground_curve(crv), .inv_ms_phase(inv), .inv_ms_ground(inv),
    .instant_sel(inst), .disc_enable(den), .control_input_pin(pin),
    .control_input_function_select(fn), .block_mask(bmask), .trip_latch_select(latch),
    .out_route(rte), .cbf_enable(cbf_en), .cbf_ms(cbf_t), .self_fault_pin(selff),
    .main_trip_output(mto), .backup_trip_output(bto), .signal_output(sig),
    .self_check_alarm_output(alarm), .stage_start(sst), .stage_operate(sop),
    .bank_second(bank));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic int sdel(input int k);
    case (k)
      0: return oce_pkg::LS_PHASE_START_MS;
      1: return oce_pkg::HS_PHASE_START_MS;
      2: return oce_pkg::VHS_PHASE_START_MS;
      3: return oce_pkg::LS_GROUND_START_MS;
      4: return oce_pkg::HS_GROUND_START_MS;
      default: return oce_pkg::DISC_START_MS;
    endcase
  endfunction

  // Expected operate time in ms after start, zero when instantaneous
  function automatic int exp_ms(input int k, input int c, input int op, input int iv,
                                input logic [2:0] ins);
    if ((k == 1 && ins[0]) || (k == 2 && ins[1]) || (k == 4 && ins[2])) return 0;
    if ((k == 0 || k == 3) && c >= 1 && c <= 6) return iv;
    return op;
  endfunction

  // Delays may slip by one free-running millisecond tick plus pipeline cycles
  function automatic bit near(input int n, input int nom);
    return n >= nom - MS - 6 && n <= nom + MS + 8;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wt(input int w, input int lim, output int n);
    n = 0;
    while (obs[w] !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic do_reset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check({alarm, mto, bto, sig}, 0);
    @(posedge clk);
    reset <= 1'b0;
    cyc(3);
    check(alarm, 1);
  endtask

  // Modes: 0 plain, 1 blocked, 2 second bank, 3 latched trip, 4 breaker stuck, 5 disabled
  task automatic run(input int k, input int c, input int mode);
    int n, op, iv, cb, eop;
    logic [2:0] ins, ph;
    op  = 2 + ($random(seed) & 3);
    iv  = 2 + ($random(seed) & 7);
    cb  = 100 + (($random(seed) & 32'hffff) % 201);
    ph  = 3'(1 + (($random(seed) & 32'hff) % 3));
    ins = (mode == 0) ? 3'($random(seed)) : 3'h0;
    eop = exp_ms(k, c, op, iv, ins);
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      lvm[i] <= (i == k && mode != 2) ? 16'h0400 : 16'hffff;
      lvs[i] <= (i == k && mode == 2) ? 16'h0400 : 16'hffff;
      rte[i] <= (i == 0) ? 12'h040 << k : ((i == 2) ? 12'h001 << k : 12'h000);
    end
    opm[k] <= op[15:0];
    ops[k] <= op[15:0];
    inv    <= iv[15:0];
    cbf_t  <= cb[15:0];
    crv    <= oce_pkg::oce_curve_t'(c[2:0]);
    inst   <= ins;
    fn     <= mode == 1 ? oce_pkg::oce_ctl_block :
              (mode == 2 ? oce_pkg::oce_ctl_bank : oce_pkg::oce_ctl_unlatch);
    pin    <= (mode == 1 || mode == 2);
    bmask  <= 6'h01 << k;
    latch  <= (mode == 3);
    cbf_en <= (mode == 4);
    stuck  <= (mode == 4);
    den    <= (mode != 5);
    amp    <= 16'h0800 + 16'($random(seed) & 32'h03ff);
    fsel   <= k < 3 ? ph : (k < 5 ? 3'h4 : 3'h5);
    if (mode == 5) begin
      cyc(MS * 200);
      check(obs[5] | obs[11], 0);
    end else begin
      wt(k, MS * 400, n);
      check(near(n, MS * sdel(k)), 1);
      if (mode == 2) check(bank, 1);
      cyc(2);
      check(obs[14], 1);
      if (mode == 1) begin
        cyc(MS * (op + 2));
        check(sop[k], 0);
        @(posedge clk);
        pin <= 1'b0;
      end
      wt(6 + k, MS * 400, n);
      if (eop == 0) check(n, 0);
      else check(near(n, MS * eop - 2), 1);
      wt(12, 10, n);
      check(n, eop == 0 ? 1 : 2);
      if (mode == 4) begin
        wt(13, MS * 400, n);
        check(near(n, MS * cb), 1);
        @(posedge clk);
        selff <= 1'b1;
        cyc(8);
        check({alarm, mto, bto, sig}, 0);
      end else begin
        cyc(60);
        check(sst[k], 0);
        check(mto, mode == 3);
        if (mode == 3) begin
          @(posedge clk);
          pin <= 1'b1;
          cyc(8);
          check(mto, 0);
        end
      end
    end
    @(posedge clk);
    fsel  <= 3'h0;
    pin   <= 1'b0;
    selff <= 1'b0;
    cyc(40);
    if (mode == 4) do_reset();
  endtask

  initial begin
    for (int i = 0; i < 6; i++) begin
      lvm[i] = 16'hffff;
      lvs[i] = 16'hffff;
      opm[i] = 16'h0002;
      ops[i] = 16'h0002;
      rte[i] = 12'h000;
    end
    do_reset();
    for (int t = 0; t < 20; t++) begin
      run(t < 6 ? t : (t < 13 ? 0 : 3), t < 6 ? 0 : (t - 6) % 7 + 1, 0);
    end
    run(1, 0, 1);
    run(2, 0, 2);
    run(0, 0, 3);
    run(5, 0, 5);
    run(3, 0, 4);
    conclude();
  end

  initial begin
    #(5000000);
    errors++;
    conclude();
  end
endmodule // oce_top_tb_top

`default_nettype wire
